// file: logic/i2ccfg_slave.sv
// two-wire slave holding eight configuration bytes
//
// Overview of operation
// - data changes only while clock low
// - sda fall/rise at scl high: start/stop
// - master frames transfers, picks length
// - surplus writes wrap over registers
// - receiver acknowledges every byte but the last read
// - ninth clock carries acknowledge
// - acknowledger holds sda low on ninth
// - master nacks last read; slave releases
// - no reference oscillator needed; this slave samples scl on clk_in instead
// - address 10110 plus two select pins
// - first write byte loads pointer
// - broken data byte is discarded
// - read follows pointer set, repeated start
// - byte committed at its acknowledge
// - pointer increments after write, wraps
// - pointer increments after read, wraps
// - sequential read wraps past last register
// - registers clear at reset
// - reads return last written value
`timescale 1ns/100ps
`include "i2ccfg_cfg.svh"
module i2ccfg_slave
    import i2ccfg_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // address select pins
    input wire logic [1:0] addr_sel_in,
    // bus
    i2ccfg_if.slave bus,
    // register contents
    output logic [`I2CCFG_NUM_REGS*8-1:0] regs_out
);
    // ***********************************
    // pin synchronisers and edge finding
    // ***********************************
    // the serial clock is sampled like data, so no oscillator beyond clk_in is needed
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] sel_sync0;
    logic [1:0] sel_sync1;
    logic scl_d;
    logic sda_d;
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            sel_sync0 <= 2'h0;
            sel_sync1 <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], bus.scl};
            sda_sync <= {sda_sync[0], bus.sda};
            sel_sync0 <= addr_sel_in;
            sel_sync1 <= sel_sync0;
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
        end
    end
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s;
    // ***********************************
    // protocol state
    // ***********************************
    i2ccfg_slv_state_t state;
    i2ccfg_slv_state_t next_state;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [`I2CCFG_PTR_W-1:0] ptr;
    logic [`I2CCFG_PTR_W-1:0] next_ptr;
    logic got_ptr;
    logic next_got_ptr;
    logic rd_mode;
    logic next_rd_mode;
    logic do_ack;
    logic next_do_ack;
    logic sda_low;
    logic next_sda_low;
    logic byte_in;
    logic next_byte_in;
    logic [7:0] regs [`I2CCFG_NUM_REGS];
    logic [7:0] next_regs [`I2CCFG_NUM_REGS];
    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_ptr = ptr;
        next_got_ptr = got_ptr;
        next_rd_mode = rd_mode;
        next_do_ack = do_ack;
        next_sda_low = sda_low;
        next_byte_in = byte_in;
        next_regs = regs;
        if (start_det)
        begin
            // partial byte in shift is simply dropped
            next_state = I2CCFG_ADDR;
            next_bit_cnt = 3'h0;
            next_got_ptr = 1'b0;
            next_byte_in = 1'b0;
            next_sda_low = 1'b0;
        end
        else if (stop_det)
        begin
            next_state = I2CCFG_IDLE;
            next_sda_low = 1'b0;
        end
        else
        begin
            unique case (state)
                I2CCFG_IDLE, I2CCFG_IGNORE:
                begin
                    next_sda_low = 1'b0;
                end
                I2CCFG_ADDR, I2CCFG_RX:
                begin
                    if (scl_rise)
                    begin
                        next_shift = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 3'h1;
                        next_byte_in = (bit_cnt == `I2CCFG_BIT_LAST);
                    end
                    if (scl_fall && byte_in)
                    begin
                        // eight bits in: decide acknowledge on the falling edge after bit 7
                        if (state == I2CCFG_ADDR)
                        begin
                            if (shift[7:1] == {`I2CCFG_ADDR_HI, sel_sync1})
                            begin
                                next_rd_mode = shift[0];
                                next_state = I2CCFG_ACK;
                                next_sda_low = 1'b1;
                            end
                            else
                            begin
                                next_state = I2CCFG_IGNORE;
                            end
                        end
                        else
                        begin
                            next_state = I2CCFG_ACK;
                            next_sda_low = 1'b1;
                            if (!got_ptr)
                            begin
                                next_ptr = shift[`I2CCFG_PTR_W-1:0];
                                next_got_ptr = 1'b1;
                            end
                            else
                            begin
                                next_regs[ptr] = shift;
                                next_ptr = ptr + 1'b1;
                            end
                        end
                    end
                end
                I2CCFG_ACK:
                begin
                    // ninth clock: at its falling edge release for a write, or drive bit 7 of regs[ptr] for a read
                    if (scl_fall)
                    begin
                        next_bit_cnt = 3'h0;
                        if (rd_mode)
                        begin
                            next_state = I2CCFG_TX;
                            next_shift = regs[ptr];
                            next_sda_low = !regs[ptr][7];
                        end
                        else
                        begin
                            next_state = I2CCFG_RX;
                            next_sda_low = 1'b0;
                        end
                    end
                end
                I2CCFG_TX:
                begin
                    if (scl_rise)
                    begin
                        next_bit_cnt = bit_cnt + 3'h1;
                    end
                    if (scl_fall)
                    begin
                        if (bit_cnt == 3'h0)
                        begin
                            next_state = I2CCFG_MACK;
                            next_sda_low = 1'b0;
                            next_ptr = ptr + 1'b1;
                        end
                        else
                        begin
                            next_shift = {shift[6:0], 1'b0};
                            next_sda_low = !shift[6];
                        end
                    end
                end
                I2CCFG_MACK:
                begin
                    if (scl_rise)
                    begin
                        next_do_ack = !sda_s;
                    end
                    if (scl_fall)
                    begin
                        next_bit_cnt = 3'h0;
                        if (do_ack)
                        begin
                            next_state = I2CCFG_TX;
                            next_shift = regs[ptr];
                            next_sda_low = !regs[ptr][7];
                        end
                        else
                        begin
                            next_state = I2CCFG_IGNORE;
                            next_sda_low = 1'b0;
                        end
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state <= I2CCFG_IDLE;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            ptr <= '0;
            got_ptr <= 1'b0;
            rd_mode <= 1'b0;
            do_ack <= 1'b0;
            sda_low <= 1'b0;
            byte_in <= 1'b0;
            for (int i = 0; i < `I2CCFG_NUM_REGS; i++)
            begin
                regs[i] <= `I2CCFG_REG_RESET;
            end
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            ptr <= next_ptr;
            got_ptr <= next_got_ptr;
            rd_mode <= next_rd_mode;
            do_ack <= next_do_ack;
            sda_low <= next_sda_low;
            byte_in <= next_byte_in;
            regs <= next_regs;
        end
    end
    assign bus.sda_out_s = 1'b0;
    assign bus.sda_oe_s = sda_low;
    genvar g;
    generate
        for (g = 0; g < `I2CCFG_NUM_REGS; g++)
        begin : g_regs
            assign regs_out[g*8 +: 8] = regs[g];
        end
    endgenerate
endmodule // i2ccfg_slave

// file: logic/i2ccfg_cfg.svh
// constants for the two-wire configuration port
`ifndef I2CCFG_CFG_SVH
`define I2CCFG_CFG_SVH
`define I2CCFG_ADDR_HI 5'h16
`define I2CCFG_NUM_REGS 8
`define I2CCFG_PTR_W 3
`define I2CCFG_REG_RESET 8'h00
`define I2CCFG_BIT_LAST 3'h7
`define I2CCFG_HALF_DIV 4
`define I2CCFG_CNT_W 8
`endif

// file: logic/i2ccfg_pkg.sv
// types shared by both ends of the configuration port
package i2ccfg_pkg;
    typedef enum logic [2:0] {I2CCFG_IDLE, I2CCFG_ADDR, I2CCFG_ACK, I2CCFG_RX, I2CCFG_TX, I2CCFG_MACK,
                              I2CCFG_IGNORE} i2ccfg_slv_state_t;
    typedef enum logic [3:0] {I2CCFG_M_IDLE, I2CCFG_M_START, I2CCFG_M_BIT_LO, I2CCFG_M_BIT_HI, I2CCFG_M_STOP_LO,
                              I2CCFG_M_STOP_HI, I2CCFG_M_STOP_END, I2CCFG_M_RS_LO, I2CCFG_M_RS_HI}
        i2ccfg_mst_state_t;
endpackage

// file: logic/i2ccfg_if.sv
// two-wire bus between master and slave, open-drain resolved here
`timescale 1ns/100ps
interface i2ccfg_if;
    logic scl_out_m;
    logic scl_oe_m;
    logic sda_out_m;
    logic sda_oe_m;
    logic sda_out_s;
    logic sda_oe_s;
    logic scl;
    logic sda;
    // wired-and with pull-ups
    assign scl = !(scl_oe_m && !scl_out_m);
    assign sda = !((sda_oe_m && !sda_out_m) || (sda_oe_s && !sda_out_s));
    modport master (output scl_out_m, output scl_oe_m, output sda_out_m, output sda_oe_m, input scl, input sda);
    modport slave (output sda_out_s, output sda_oe_s, input scl, input sda);
endinterface

// file: logic/i2ccfg_master.sv
// two-wire master issuing single byte-level bus steps
`timescale 1ns/100ps
`include "i2ccfg_cfg.svh"
module i2ccfg_master
    import i2ccfg_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // command: start+byte, byte, repeated start+byte, each optionally followed by a stop
    input wire logic cmd_valid_in,
    input wire logic cmd_start_in,
    input wire logic cmd_stop_in,
    input wire logic cmd_read_in,
    input wire logic cmd_ack_in,
    input wire logic [7:0] cmd_data_in,
    output logic cmd_ready_out,
    // answer
    output logic done_out,
    output logic [7:0] rd_data_out,
    output logic ack_seen_out,
    // bus
    i2ccfg_if.master bus
);
    // ***********************************
    // divider: one tick per third of the serial clock (two ticks low, one high)
    // ***********************************
    logic [`I2CCFG_CNT_W-1:0] div;
    logic [`I2CCFG_CNT_W-1:0] next_div;
    logic tick;
    assign tick = (div == '0);
    assign next_div = tick ? `I2CCFG_CNT_W'(`I2CCFG_HALF_DIV - 1) : div - 1'b1;
    logic sda_s0;
    logic sda_s;
    // ***********************************
    // sequencer
    // ***********************************
    i2ccfg_mst_state_t state;
    i2ccfg_mst_state_t next_state;
    logic [3:0] bit_n;
    logic [3:0] next_bit_n;
    logic [8:0] sh;
    logic [8:0] next_sh;
    logic [8:0] rx;
    logic [8:0] next_rx;
    logic scl_o;
    logic next_scl_o;
    logic sda_o;
    logic next_sda_o;
    logic stop_pend;
    logic next_stop_pend;
    logic done;
    logic next_done;
    assign cmd_ready_out = (state == I2CCFG_M_IDLE);
    always_comb
    begin
        next_state = state;
        next_bit_n = bit_n;
        next_sh = sh;
        next_rx = rx;
        next_scl_o = scl_o;
        next_sda_o = sda_o;
        next_stop_pend = stop_pend;
        next_done = 1'b0;
        unique case (state)
            I2CCFG_M_IDLE:
            begin
                if (cmd_valid_in)
                begin
                    // read byte sends ones and ack bit; write byte releases ninth bit
                    next_sh = cmd_read_in ? {8'hff, !cmd_ack_in} : {cmd_data_in, 1'b1};
                    next_stop_pend = cmd_stop_in;
                    next_bit_n = 4'h0;
                    next_state = !cmd_start_in ? I2CCFG_M_BIT_LO : (scl_o ? I2CCFG_M_START : I2CCFG_M_RS_LO);
                end
            end
            I2CCFG_M_RS_LO:
            begin
                if (tick)
                begin
                    next_sda_o = 1'b1;
                    next_state = I2CCFG_M_RS_HI;
                end
            end
            I2CCFG_M_RS_HI:
            begin
                if (tick)
                begin
                    next_scl_o = 1'b1;
                    next_state = I2CCFG_M_START;
                end
            end
            I2CCFG_M_START:
            begin
                if (tick)
                begin
                    next_sda_o = 1'b0;
                    next_state = I2CCFG_M_BIT_LO;
                end
            end
            I2CCFG_M_BIT_LO:
            begin
                if (tick)
                begin
                    if (!scl_o)
                    begin
                        next_sda_o = sh[8];
                        next_state = I2CCFG_M_BIT_HI;
                    end
                    next_scl_o = 1'b0;
                end
            end
            I2CCFG_M_BIT_HI:
            begin
                if (tick)
                begin
                    if (!scl_o)
                    begin
                        next_scl_o = 1'b1;
                    end
                    else
                    begin
                        next_rx = {rx[7:0], sda_s};
                        next_sh = {sh[7:0], 1'b1};
                        next_bit_n = bit_n + 4'h1;
                        next_scl_o = 1'b0;
                        // nine clocks per byte, the last for the acknowledge
                        if (bit_n == 4'h8)
                        begin
                            next_state = stop_pend ? I2CCFG_M_STOP_LO : I2CCFG_M_IDLE;
                            next_done = !stop_pend;
                        end
                        else
                        begin
                            next_state = I2CCFG_M_BIT_LO;
                        end
                    end
                end
            end
            I2CCFG_M_STOP_LO:
            begin
                if (tick)
                begin
                    next_sda_o = 1'b0;
                    next_state = I2CCFG_M_STOP_HI;
                end
            end
            I2CCFG_M_STOP_HI:
            begin
                if (tick)
                begin
                    next_scl_o = 1'b1;
                    next_state = I2CCFG_M_STOP_END;
                end
            end
            I2CCFG_M_STOP_END:
            begin
                if (tick)
                begin
                    next_sda_o = 1'b1;
                    next_state = I2CCFG_M_IDLE;
                    next_done = 1'b1;
                end
            end
        endcase
    end
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            div <= '0;
            sda_s0 <= 1'b1;
            sda_s <= 1'b1;
            state <= I2CCFG_M_IDLE;
            bit_n <= 4'h0;
            sh <= 9'h1ff;
            rx <= 9'h000;
            scl_o <= 1'b1;
            sda_o <= 1'b1;
            stop_pend <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            div <= next_div;
            sda_s0 <= bus.sda;
            sda_s <= sda_s0;
            state <= next_state;
            bit_n <= next_bit_n;
            sh <= next_sh;
            rx <= next_rx;
            scl_o <= next_scl_o;
            sda_o <= next_sda_o;
            stop_pend <= next_stop_pend;
            done <= next_done;
        end
    end
    assign bus.scl_out_m = 1'b0;
    assign bus.scl_oe_m = !scl_o;
    assign bus.sda_out_m = 1'b0;
    assign bus.sda_oe_m = !sda_o;
    assign done_out = done;
    assign rd_data_out = rx[8:1];
    assign ack_seen_out = !rx[0];
endmodule // i2ccfg_master

// file: sim/i2ccfg_props.sv
// assertions on the link that joins the master and slave ends
`timescale 1ns/100ps
`include "i2ccfg_cfg.svh"
module i2ccfg_props
(
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // watched signals
    input wire logic [1:0] addr_sel_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_oe_s
);
    // ****
    // bus tracking
    // ****
    logic scl_q, sda_q, adr_done, matched, rd, quiet;
    logic next_adr_done, next_matched, next_rd, next_quiet;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] sh, next_sh;
    logic rise, start_det, stop_det, ninth, hit;
    assign rise = scl && !scl_q;
    assign start_det = scl && scl_q && sda_q && !sda;
    assign stop_det = scl && scl_q && !sda_q && sda;
    assign ninth = rise && bit_cnt == 4'h8;
    assign hit = sh[7:1] == {`I2CCFG_ADDR_HI, addr_sel_in};
    always_comb
    begin
        next_bit_cnt = bit_cnt;
        next_sh = sh;
        next_adr_done = adr_done;
        next_matched = matched;
        next_rd = rd;
        next_quiet = quiet;
        if (start_det || stop_det)
        begin
            next_bit_cnt = 4'h0;
            next_adr_done = 1'b0;
            next_matched = 1'b0;
            next_quiet = 1'b0;
        end
        else if (rise)
        begin
            // 4'ha marks the first high after an acknowledge: bit one, or the set-up of a start or stop
            next_bit_cnt = (bit_cnt == 4'h9) ? 4'ha : (bit_cnt == 4'ha) ? 4'h2 : bit_cnt + 4'h1;
            if (!ninth)
                next_sh = {sh[6:0], sda};
            if (ninth && !adr_done)
            begin
                next_adr_done = 1'b1;
                next_matched = hit;
                next_rd = sh[0];
                next_quiet = !hit;
            end
            // a nack from the master ends a read; the slave must stay off the line
            else if (ninth && matched && rd && sda)
                next_quiet = 1'b1;
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            {scl_q, sda_q, adr_done, matched, rd, quiet, bit_cnt, sh} <= {6'h30, 4'h0, 8'h00};
        else
            {scl_q, sda_q, adr_done, matched, rd, quiet, bit_cnt, sh} <=
                {scl, sda, next_adr_done, next_matched, next_rd, next_quiet, next_bit_cnt, next_sh};
    end
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    slave_edge_a: assert property ($changed(sda_oe_s) |-> !scl)
        else $error("slave moved sda while scl high");
    wire_edge_a: assert property (scl && scl_q && sda != sda_q |-> bit_cnt == 4'h0 || bit_cnt == 4'ha)
        else $error("sda moved inside a bit");
    addr_ack_a: assert property (ninth && !adr_done && hit |-> !sda)
        else $error("own address not acknowledged");
    addr_nack_a: assert property (ninth && !adr_done && !hit |-> sda)
        else $error("foreign address acknowledged");
    data_ack_a: assert property (ninth && adr_done && matched && !rd |-> !sda)
        else $error("written byte not acknowledged");
    ack_hold_a: assert property (ninth && !sda |-> (!sda) [*6])
        else $error("acknowledge not held while scl high");
    rd_release_a: assert property (ninth && adr_done && rd |-> !sda_oe_s)
        else $error("slave drives during master acknowledge");
    slave_silent_a: assert property (quiet |-> !sda_oe_s)
        else $error("slave drives while it should be silent");
    nine_clk_a: assert property (stop_det |-> bit_cnt == 4'ha)
        else $error("stop not after a whole byte and acknowledge");
endmodule // i2ccfg_props

// file: sim/i2c_slave_config_port_test.sv
// self-checking bench for the configuration port, both ends on one link
`timescale 1ns/100ps
`include "i2ccfg_cfg.svh"
`define CHK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin $display("mismatch %s expected %h seen %h", nm, ex, sn); err_count++; end end
module i2c_slave_config_port_test;
    logic clk_in, arst_n_in, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack;
    logic cmd_ready, done, ack_seen, bb_ack;
    logic [1:0] sel;
    logic [7:0] cmd_data, rd_data;
    logic [`I2CCFG_NUM_REGS*8-1:0] regs_a, regs_b, exp_b;
    logic [31:0] rnd;
    logic [7:0] mdl [8];
    int ptr_m, err_count, checked, p;
    i2ccfg_if bus_a();
    i2ccfg_if bus_b();
    i2ccfg_master i2ccfg_master_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid),
        .cmd_start_in(cmd_start), .cmd_stop_in(cmd_stop), .cmd_read_in(cmd_read), .cmd_ack_in(cmd_ack),
        .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .done_out(done), .rd_data_out(rd_data),
        .ack_seen_out(ack_seen), .bus(bus_a.master));
    i2ccfg_slave i2ccfg_slave_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_sel_in(sel),
        .bus(bus_a.slave), .regs_out(regs_a));
    // second slave faces a bench-driven master that breaks bytes on purpose
    i2ccfg_slave i2ccfg_slave_inst2 (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_sel_in(2'b00),
        .bus(bus_b.slave), .regs_out(regs_b));
    i2ccfg_props i2ccfg_props_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_sel_in(sel),
        .scl(bus_a.scl), .sda(bus_a.sda), .sda_oe_s(bus_a.sda_oe_s));
    // ****
    // helpers
    // ****
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] adr(input logic [1:0] s, input logic rw);
        return {`I2CCFG_ADDR_HI, s, rw};
    endfunction
    function automatic logic [63:0] mdl_vec();
        logic [63:0] v;
        for (int j = 0; j < 8; j++)
            v[8*j +: 8] = mdl[j];
        return v;
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one byte step on the master: flags are start, stop, read, ack
    task automatic step(input logic [3:0] f, input logic [7:0] d);
        int n;
        n = 0;
        {cmd_start, cmd_stop, cmd_read, cmd_ack} = f;
        cmd_data = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 200)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        @(posedge clk_in);
        #1;
        cmd_valid = 1'b0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (done !== 1'b1)
        begin
            err_count++;
            summarize();
        end
    endtask
    task automatic wr(input int q, input int cnt);
        step(4'h8, adr(sel, 1'b0));
        `CHK("addr ack", 1'b1, ack_seen)
        rnd = lfsr(rnd);
        step(4'h0, {rnd[7:3], q[2:0]});
        `CHK("ptr ack", 1'b1, ack_seen)
        ptr_m = q;
        for (int i = 0; i < cnt; i++)
        begin
            rnd = lfsr(rnd);
            step({1'b0, i == cnt - 1, 2'b00}, rnd[7:0]);
            mdl[ptr_m] = rnd[7:0];
            ptr_m = (ptr_m + 1) % `I2CCFG_NUM_REGS;
            `CHK("data ack", 1'b1, ack_seen)
            `CHK("regs at ack", mdl_vec(), regs_a)
        end
    endtask
    task automatic rd(input int q, input int cnt);
        step(4'h8, adr(sel, 1'b0));
        step(4'h0, {5'h00, q[2:0]});
        ptr_m = q;
        step(4'h8, adr(sel, 1'b1));
        `CHK("read addr ack", 1'b1, ack_seen)
        for (int i = 0; i < cnt; i++)
        begin
            step({1'b0, i == cnt - 1, 1'b1, i != cnt - 1}, 8'h00);
            `CHK("read data", mdl[ptr_m], rd_data)
            ptr_m = (ptr_m + 1) % `I2CCFG_NUM_REGS;
        end
    endtask
    // bench-driven link: 800 ns bit, scl still between frames
    task automatic bb_bit(input logic b);
        bus_b.sda_oe_m = !b;
        #200 bus_b.scl_oe_m = 1'b0;
        #400 bus_b.scl_oe_m = 1'b1;
        #200;
    endtask
    task automatic bb_byte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--)
            bb_bit(v[i]);
        bus_b.sda_oe_m = 1'b0;
        #200 bus_b.scl_oe_m = 1'b0;
        #200 ack = !bus_b.sda;
        #200 bus_b.scl_oe_m = 1'b1;
        #200;
    endtask
    task automatic bb_start();
        bus_b.sda_oe_m = 1'b0;
        #200 bus_b.scl_oe_m = 1'b0;
        #200 bus_b.sda_oe_m = 1'b1;
        #200 bus_b.scl_oe_m = 1'b1;
        #200;
    endtask
    task automatic bb_stop();
        bus_b.sda_oe_m = 1'b1;
        #200 bus_b.scl_oe_m = 1'b0;
        #200 bus_b.sda_oe_m = 1'b0;
        #200;
    endtask
    // ****
    // stimulus
    // ****
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial
    begin
        arst_n_in = 1'b0;
        cmd_valid = 1'b0;
        {cmd_start, cmd_stop, cmd_read, cmd_ack} = 4'h0;
        cmd_data = 8'h00;
        {bus_b.scl_out_m, bus_b.scl_oe_m, bus_b.sda_out_m, bus_b.sda_oe_m} = 4'h0;
        sel = 2'b10;
        rnd = 32'hbd56;
        err_count = 0;
        checked = 0;
        ptr_m = 0;
        for (int j = 0; j < 8; j++)
            mdl[j] = 8'h00;
        repeat (4) @(posedge clk_in);
        #1;
        arst_n_in = 1'b1;
        `CHK("reset regs a", 64'h0, regs_a)
        `CHK("reset regs b", 64'h0, regs_b)
        rd(0, 8);
        wr(5, 10);
        rd(3, 8);
        for (int k = 0; k < 4; k++)
        begin
            sel = k[1:0];
            repeat (4) @(posedge clk_in);
            #1;
            rnd = lfsr(rnd);
            p = rnd[10:8];
            wr(p, 1);
            rd(p, 2);
        end
        step(4'h8, adr(~sel, 1'b0));
        `CHK("foreign addr ack", 1'b0, ack_seen)
        step(4'h4, 8'h00);
        `CHK("ignored byte ack", 1'b0, ack_seen)
        `CHK("regs after foreign", mdl_vec(), regs_a)
        exp_b = 64'h0;
        bb_start();
        bb_byte(adr(2'b00, 1'b0), bb_ack);
        `CHK("b addr ack", 1'b1, bb_ack)
        bb_byte(8'h02, bb_ack);
        bb_byte(8'ha5, bb_ack);
        exp_b[23:16] = 8'ha5;
        `CHK("b data ack", 1'b1, bb_ack)
        repeat (4) bb_bit(1'b1);
        bb_stop();
        `CHK("stop mid byte", exp_b, regs_b)
        bb_start();
        bb_byte(adr(2'b00, 1'b0), bb_ack);
        bb_byte(8'h04, bb_ack);
        repeat (3) bb_bit(1'b1);
        bb_start();
        bb_byte(adr(2'b00, 1'b0), bb_ack);
        `CHK("restart addr ack", 1'b1, bb_ack)
        bb_byte(8'h05, bb_ack);
        bb_stop();
        `CHK("restart mid byte", exp_b, regs_b)
        summarize();
    end
endmodule // i2c_slave_config_port_test
